// ==== atc_map.vh ====
// register map and constants of the antenna tuner control port
`ifndef ATC_MAP_VH
`define ATC_MAP_VH
`define ATC_REG_CTRL      4'h0
`define ATC_REG_SEL       4'h4
`define ATC_REG_STAT      4'h8
`define ATC_CTRL_BAND     0
`define ATC_CTRL_SCAN     1
`define ATC_CTRL_KEY      2
`define ATC_CTRL_SPEC     3
`define ATC_CTRL_TUNE     4
`define ATC_CTRL_ABORT    5
`define ATC_CTRL_RESET    32'h00000000
`define ATC_SEL_RESET     32'h00000000
`define ATC_STAT_BUSY     0
`define ATC_STAT_DONE     1
`define ATC_STAT_OK       2
`define ATC_STAT_FAIL     3
`define ATC_PULL_NS       1000
`define ATC_CLK_NS        5
`define ATC_PULL_CYC      8'hC8
`define ATC_RESP_OKAY     2'b00
`define ATC_RESP_SLVERR   2'b10
`endif

// ==== atc_port.v ====
// antenna tuner control port with axi4-lite register slave
//
// How it works
// - drive four-bit code; three bits channel/band
// - fourth bit carries special function flag
// - channel mode: code cycles every nine channels
// - band mode: code from frequency thresholds
// - tuner holds request low; stay tuning
// - sample result line at completion
// - scan select output low in scan
// - keying output high while transmit keyed
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`include "atc_map.vh"
module atc_port (
  input  wire        sys_clk,
  input  wire        rstn,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [3:0]  ant_code,
  output reg         scan_sel_n,
  output reg         transmit_keying,
  input  wire        tune_req_in,
  output reg         tune_req_out,
  output reg         tune_req_oe_n,
  input  wire        tuned_in
);

  localparam ST_IDLE = 4'b0001;
  localparam ST_PULL = 4'b0010;
  localparam ST_WAIT = 4'b0100;
  localparam ST_DONE = 4'b1000;
  // pull time is fixed; a slow tuner only stretches the wait
  localparam [7:0] PULL_CYC = `ATC_PULL_CYC;

  // sel holds a channel number, or a frequency in 10 kHz steps
  reg [3:0]  ctrl;
  reg [15:0] sel;
  reg [3:0]  state;
  reg [7:0]  cnt;
  reg        done;
  reg        ok;
  reg        fail;
  reg        aw_hold;
  reg        w_hold;
  reg [3:0]  aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  reg [3:0]  next_state;
  reg [7:0]  next_cnt;
  reg        next_oe_n;
  reg [31:0] next_rdata;
  reg [1:0]  next_rresp;
  wire [15:0] next_sel;

  // nine-channel cycle; channel eight shows as zero in three bits
  function [2:0] chan_code;
    input [15:0] ch;
    reg   [15:0] rem;
    begin
      rem       = ch % 16'h0009;
      chan_code = rem[2:0];
    end
  endfunction

  // frequency in 10 kHz units; 200 = 2.0 MHz
  function [2:0] band_code;
    input [15:0] f;
    begin
      if (f < 16'h00C8)
        band_code = 3'h1;
      else if (f < 16'h012C)
        band_code = 3'h2;
      else if (f < 16'h01F4)
        band_code = 3'h3;
      else if (f < 16'h0320)
        band_code = 3'h4;
      else if (f < 16'h0514)
        band_code = 3'h5;
      else if (f < 16'h07D0)
        band_code = 3'h6;
      else
        band_code = 3'h7;
    end
  endfunction

  // mapped offsets; shared by the write answer and the read mux
  function reg_hit;
    input [3:0] a;
    begin
      reg_hit = (a == `ATC_REG_CTRL) || (a == `ATC_REG_SEL) ||
                (a == `ATC_REG_STAT);
    end
  endfunction

  wire [2:0] next_code = ctrl[`ATC_CTRL_BAND] ? band_code(sel)
                                              : chan_code(sel);
  // a write goes once both halves are in and no answer is pending
  wire wr_go = (aw_hold | (s_axi_awvalid & s_axi_awready)) &
               (w_hold | (s_axi_wvalid & s_axi_wready)) & ~s_axi_bvalid;
  wire [3:0]  wa = aw_hold ? aw_addr : s_axi_awaddr;
  wire [31:0] wd = w_hold ? w_data : s_axi_wdata;
  wire [3:0]  ws = w_hold ? w_strb : s_axi_wstrb;

  wire wr_ctrl = wr_go & (wa == `ATC_REG_CTRL);
  wire wr_sel = wr_go & (wa == `ATC_REG_SEL);
  wire wr_stat = wr_go & (wa == `ATC_REG_STAT);

  wire tune_start = wr_ctrl & ws[0] & wd[`ATC_CTRL_TUNE];
  // abort is honoured only while waiting; a pull always runs out
  wire tune_abort = wr_ctrl & ws[0] & wd[`ATC_CTRL_ABORT];
  wire tune_end = (state == ST_WAIT) & tune_req_in;
  wire busy = (state != ST_IDLE);

  // each byte lane of the selection word follows its own strobe
  genvar lane;
  generate
    for (lane = 0; lane < 2; lane = lane + 1) begin : g_sel_lane
      assign next_sel[lane*8 +: 8] = (wr_sel & ws[lane]) ? wd[lane*8 +: 8]
                                                         : sel[lane*8 +: 8];
    end
  endgenerate

  // write channel: address and data taken in either order
  // readies pulse one cycle, so a held valid is taken only once
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ATC_RESP_OKAY;
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      aw_addr       <= 4'h0;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      ctrl          <= 4'h0;
      sel           <= 16'h0000;
    end else begin
      s_axi_awready <= ~aw_hold & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready  <= ~w_hold & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid & s_axi_awready & ~wr_go) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready & ~wr_go) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold       <= 1'b0;
        w_hold        <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= reg_hit(wa) ? `ATC_RESP_OKAY : `ATC_RESP_SLVERR;
        // ctrl keeps only the level bits; tune and abort act on the write
        if (wr_ctrl && ws[0])
          ctrl <= wd[3:0];
        sel <= next_sel;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // tune sequencer; abort only sends the wait back to idle, setting no flags
  always @* begin
    next_state = state;
    next_cnt   = cnt;
    next_oe_n  = tune_req_oe_n;
    case (state)
      ST_IDLE: begin
        if (tune_start) begin
          next_state = ST_PULL;
          next_cnt   = PULL_CYC;
          next_oe_n  = 1'b0;
        end
      end
      ST_PULL: begin
        if (cnt == 8'h01) begin
          next_state = ST_WAIT;
          next_oe_n  = 1'b1;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      ST_WAIT: begin
        // tuner keeps the line low while it works
        // a tuner that never lets go needs the abort bit
        if (tune_end)
          next_state = ST_DONE;
        else if (tune_abort)
          next_state = ST_IDLE;
      end
      ST_DONE: begin
        // spare cycle: flags are set before busy drops
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
        next_oe_n  = 1'b1;
      end
    endcase
  end

  // line is only ever pulled low; the pull-up makes the high
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state         <= ST_IDLE;
      cnt           <= 8'h00;
      tune_req_out  <= 1'b0;
      tune_req_oe_n <= 1'b1;
    end else begin
      state         <= next_state;
      cnt           <= next_cnt;
      tune_req_oe_n <= next_oe_n;
    end
  end

  // sticky result flags; hardware set beats software clear
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      done <= 1'b0;
      ok   <= 1'b0;
      fail <= 1'b0;
    end else begin
      if (tune_end) begin
        done <= 1'b1;
        ok   <= tuned_in;
        fail <= ~tuned_in;
      end else if (wr_stat & ws[0]) begin
        done <= done & ~wd[`ATC_STAT_DONE];
        ok   <= ok & ~wd[`ATC_STAT_OK];
        fail <= fail & ~wd[`ATC_STAT_FAIL];
      end
    end
  end

  // connector outputs, all registered
  // pins follow a register write one cycle later
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ant_code        <= 4'h0;
      scan_sel_n      <= 1'b1;
      transmit_keying <= 1'b0;
    end else begin
      ant_code[2:0]   <= next_code;
      ant_code[3]     <= ctrl[`ATC_CTRL_SPEC];
      scan_sel_n      <= ~ctrl[`ATC_CTRL_SCAN];
      transmit_keying <= ctrl[`ATC_CTRL_KEY];
    end
  end

  // read data chosen ahead of the register; unmapped reads give zero
  always @* begin
    next_rresp = reg_hit(s_axi_araddr) ? `ATC_RESP_OKAY : `ATC_RESP_SLVERR;
    case (s_axi_araddr)
      `ATC_REG_CTRL: next_rdata = {28'h0000000, ctrl};
      `ATC_REG_SEL:  next_rdata = {16'h0000, sel};
      `ATC_REG_STAT: next_rdata = {28'h0000000, fail, ok, done,
                                   busy};
      default:       next_rdata = 32'h00000000;
    endcase
  end

  // read channel, one read at a time
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `ATC_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= next_rdata;
        s_axi_rresp   <= next_rresp;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// ==== atc_assertions.sv ====
// checker for the antenna tuner control port
`timescale 1ns/100ps
`include "atc_map.vh"
module atc_chk (
  input logic        sys_clk,
  input logic        rstn,
  input logic        s_axi_awready,
  input logic        s_axi_arready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [1:0]  s_axi_rresp,
  input logic [31:0] s_axi_rdata,
  input logic        tune_req_in,
  input logic        tune_req_out,
  input logic        tune_req_oe_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic [8:0] pcnt;
  // pull length counter, exact so one cycle off shows
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn) pcnt <= '0;
    else pcnt <= tune_req_oe_n ? '0 : pcnt + 9'h1;
  a_pull_len: assert property ($rose(tune_req_oe_n) |-> pcnt == `ATC_PULL_CYC)
    else $error("pull length wrong");
  a_pull_bound: assert property (pcnt <= `ATC_PULL_CYC)
    else $error("pull too long");
  a_drive_low: assert property (tune_req_out == 1'h0)
    else $error("tune line driven high");
  a_no_repull: assert property (tune_req_oe_n && !tune_req_in |=> tune_req_oe_n)
    else $error("line pulled again while tuner holds");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped");
  a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while response pending");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while response pending");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == `ATC_RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("unmapped read data not zero");
  c_tune: cover property ($fell(tune_req_oe_n));
  c_hold: cover property (tune_req_oe_n && !tune_req_in);
  c_err: cover property (s_axi_bvalid && s_axi_bresp == `ATC_RESP_SLVERR);
endmodule
bind atc_port atc_chk atc_chk_inst (.*);

// ==== atc_tuner.sv ====
// model of the external automatic antenna tuner
`timescale 1ns/100ps
module atc_tuner (
  input  logic sys_clk,
  input  logic rstn,
  input  logic dev_oe_n,
  input  int   hold,
  input  logic res,
  output logic line,
  output logic tuned_in
);
  logic busy;
  int   cnt;
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn) busy <= 1'h0;
    else if (!dev_oe_n) busy <= 1'h1;
    else if (busy && cnt == 0) busy <= 1'h0;
  always_ff @(posedge sys_clk)
    cnt <= !dev_oe_n ? hold : cnt - 1;
  // pull-up: high unless either side pulls
  assign line = dev_oe_n && !busy;
  // wrong level while tuning so early sampling shows
  assign tuned_in = busy ? !res : res;
endmodule

// ==== tb.sv ====
// testbench of the antenna tuner control port
`timescale 1ns/100ps
`include "atc_map.vh"
module tb;
  logic        sys_clk = 1'h0, rstn = 1'h0;
  logic [3:0]  s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, res = 1'h1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, scan_sel_n, transmit_keying, tuned_in;
  logic        tune_req_in, tune_req_out, tune_req_oe_n;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [3:0]  ant_code, m;
  int          chs[5] = '{1, 8, 9, 10, 17};
  int          n_errors = 0, n_tests = 0, hold = 20, i, f;
  int          fs[12] = '{199, 200, 299, 300, 499, 500, 799, 800, 1299, 1300,
                          1999, 2000};
  always #2.5 sys_clk = ~sys_clk;
  atc_port atc_port_inst (.*);
  atc_tuner atc_tuner_inst (.sys_clk, .rstn, .dev_oe_n(tune_req_oe_n),
    .hold, .res, .line(tune_req_in), .tuned_in);
  task end_sim;
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task to;
    n_errors++;
    end_sim;
  endtask
  task chk(input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // bready comes late on purpose so the slave must hold its answer
  task wr(input logic [3:0] a, input logic [31:0] v);
    int j;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    for (j = 0; j < 50; j++) begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid && s_axi_bready) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        return;
      end
      if (s_axi_bvalid) s_axi_bready <= 1'h1;
    end
    to;
  endtask
  task rd(input logic [3:0] a);
    int j;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    for (j = 0; j < 50; j++) begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid && s_axi_rready) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        return;
      end
      if (s_axi_rvalid) s_axi_rready <= 1'h1;
    end
    to;
  endtask
  task wait_idle;
    int j;
    for (j = 0; j < 300; j++) begin
      rd(`ATC_REG_STAT);
      if (d[0] === 1'h0) return;
    end
    to;
  endtask
  function automatic logic [3:0] band(int f);
    band = 4'(1 + (f >= 200) + (f >= 300) + (f >= 500) + (f >= 800)
      + (f >= 1300) + (f >= 2000));
  endfunction
  // code steps with the channel and restarts at zero on channel nine
  function automatic logic [2:0] chan(int n);
    chan = 3'(n % 9);
  endfunction
  initial begin
    void'($urandom(55032));
    repeat (5) @(posedge sys_clk);
    chk(32'h05, {ant_code, scan_sel_n, transmit_keying, tune_req_oe_n});
    rstn <= 1'h1;
    rd(`ATC_REG_CTRL);
    chk(`ATC_CTRL_RESET, d);
    rd(`ATC_REG_SEL);
    chk(`ATC_SEL_RESET, d);
    for (i = 0; i < 12; i++) begin
      f = i < 5 ? chs[i] : $urandom_range(300, 1);
      m = 4'($urandom_range(7, 0) << 1);
      wr(`ATC_REG_SEL, f);
      wr(`ATC_REG_CTRL, m);
      repeat (2) @(posedge sys_clk);
      chk({m[3], chan(f)}, ant_code);
      chk(!m[1], scan_sel_n);
      chk(m[2], transmit_keying);
    end
    $display("test channel done");
    wr(`ATC_REG_CTRL, 32'h1);
    for (i = 0; i < 18; i++) begin
      f = i < 12 ? fs[i] : $urandom_range(4000, 0);
      wr(`ATC_REG_SEL, f);
      repeat (2) @(posedge sys_clk);
      chk(band(f), ant_code);
      rd(`ATC_REG_SEL);
      chk(f, d);
    end
    $display("test band done");
    wr(4'hC, 32'hFFFF);
    chk(`ATC_RESP_SLVERR, r);
    rd(4'hC);
    chk(`ATC_RESP_SLVERR, r);
    chk(32'h0, d);
    $display("test unmapped done");
    for (i = 0; i < 2; i++) begin
      res <= i == 0;
      hold <= 60 + $urandom_range(40, 0);
      wr(`ATC_REG_CTRL, 32'h10);
      repeat (230) @(posedge sys_clk);
      rd(`ATC_REG_STAT);
      chk(32'h1, d);
      wait_idle;
      chk(res ? 32'h6 : 32'hA, d);
      wr(`ATC_REG_STAT, 32'hE);
      rd(`ATC_REG_STAT);
      chk(32'h0, d);
    end
    $display("test tune done");
    hold <= 900;
    wr(`ATC_REG_CTRL, 32'h10);
    repeat (300) @(posedge sys_clk);
    wr(`ATC_REG_CTRL, 32'h20);
    rd(`ATC_REG_STAT);
    chk(32'h0, d & 32'h1);
    $display("test abort done");
    end_sim;
  end
endmodule
